// [hdl/uart_ctrl_pkg.sv]
// How it works
// - fifo enable bit turns both fifos on or off; other bits need it set
// - fifo reset bits act only in a write that also sets fifo enable
// - receive fifo reset clears rx pointers only, then drops back by itself
// - transmit fifo reset clears tx pointers only, then drops back by itself
// - dma select: 0 normal ready pins, 1 dma style ready pins while fifo enable is set
// - rx trigger field picks 1, 4, 8 or 14 characters for the receive event
// - word length field gives 5, 6, 7 or 8 data bits
// - stop select: one stop, or 1.5 for 5-bit words and 2 otherwise
// - parity enable adds a parity bit on transmit and checks it on receive
// - parity type: 0 odd, 1 even, same for both directions
// - forced parity: bit is 1 when type is 0, 0 when type is 1
// - break bit holds the serial output at space until cleared
// - divisor access bit steers shared low addresses to divisor latches
// - terminal ready bit drives its active-low pin inverted
// - request to send bit drives its active-low pin inverted
// - hidden output-one bit feeds internal ring signal in loopback
// - in loopback the ring status follows output-one, not the ring pin
// - fifo status bits read 11 when fifos enabled, 00 when disabled
package uart_ctrl_pkg;
  // byte addresses on the register bus
  localparam logic [7:0] FIFO_CTRL_ADDR = 8'h08;
  localparam logic [7:0] LINE_FMT_ADDR = 8'h0c;
  localparam logic [7:0] MODEM_OUT_ADDR = 8'h10;
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h20;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // fifo_control fields
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int FCR_DMA_BIT = 3;
  localparam int FCR_TRIG_LSB = 6;
  // line_format_control fields
  localparam int LCR_WLEN_LSB = 0;
  localparam int LCR_STOP_BIT = 2;
  localparam int LCR_PEN_BIT = 3;
  localparam int LCR_PTYPE_BIT = 4;
  localparam int LCR_PFORCE_BIT = 5;
  localparam int LCR_BRK_BIT = 6;
  localparam int LCR_DLAB_BIT = 7;
  // modem_output_control fields
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_OUT1_BIT = 2;
  localparam int MCR_LOOP_BIT = 4;
  localparam logic [7:0] MCR_USED_MASK = 8'h1f;
  // reset values
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  // receive trigger levels
  typedef logic [3:0] trig_t;
  localparam trig_t TRIG_LVL_1 = 4'h1;
  localparam trig_t TRIG_LVL_4 = 4'h4;
  localparam trig_t TRIG_LVL_8 = 4'h8;
  localparam trig_t TRIG_LVL_14 = 4'he;
  localparam int TRIG_W = 4;
  // character format
  localparam logic [3:0] WLEN_BASE = 4'h5;
  localparam logic [1:0] WLEN_FIVE = 2'h0;
  localparam logic [2:0] STOP_HALF_ONE = 3'h2;
  localparam logic [2:0] STOP_HALF_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_HALF_TWO = 3'h4;
  typedef enum logic [2:0] {
    PAR_NONE = 3'b000,
    PAR_ODD = 3'b001,
    PAR_EVEN = 3'b010,
    PAR_MARK = 3'b011,
    PAR_SPACE = 3'b100
  } parity_e;
  // interrupt source nibble with nothing pending
  localparam logic [3:0] ISR_NONE_PENDING = 4'h1;
endpackage

// [hdl/line_format_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module line_format_decode
  import uart_ctrl_pkg::*;
(
  // raw format byte
  input wire logic [7:0] line_format_control_i,
  // decoded format
  output logic [3:0] data_bits_o,
  output logic [2:0] stop_half_bits_o,
  output parity_e parity_mode_o
);
  logic [1:0] wlen;
  logic pen;
  logic ptype;
  logic pforce;

  always_comb begin
    wlen = line_format_control_i[LCR_WLEN_LSB +: 2];
    pen = line_format_control_i[LCR_PEN_BIT];
    ptype = line_format_control_i[LCR_PTYPE_BIT];
    pforce = line_format_control_i[LCR_PFORCE_BIT];
    data_bits_o = WLEN_BASE + {2'h0, wlen};
    if (!line_format_control_i[LCR_STOP_BIT]) begin
      stop_half_bits_o = STOP_HALF_ONE;
    end else if (wlen == WLEN_FIVE) begin
      stop_half_bits_o = STOP_HALF_ONE_HALF;
    end else begin
      stop_half_bits_o = STOP_HALF_TWO;
    end
    if (!pen) begin
      parity_mode_o = PAR_NONE;
    end else if (pforce) begin
      parity_mode_o = ptype ? PAR_SPACE : PAR_MARK;
    end else begin
      parity_mode_o = ptype ? PAR_EVEN : PAR_ODD;
    end
  end
endmodule
`default_nettype wire

// [hdl/uart_line_modem_ctrl.sv]
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module uart_line_modem_ctrl
  import uart_ctrl_pkg::*;
#(
  parameter int COUNT_W = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // fifo side
  input wire logic [COUNT_W-1:0] rx_fifo_count_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_fifo_full_i,
  output logic fifo_enable_o,
  output logic rx_fifo_reset_o,
  output logic tx_fifo_reset_o,
  output logic dma_mode_o,
  output logic rx_trigger_o,
  output logic [1:0] fifo_status_o,
  // dma ready pins
  output logic transmit_ready_pin_n_o,
  output logic receive_ready_pin_n_o,
  // character format
  output logic [3:0] data_bits_o,
  output logic [2:0] stop_half_bits_o,
  output parity_e parity_mode_o,
  output logic divisor_access_o,
  // serial line
  input wire logic tx_serial_i,
  output logic tx_line_o,
  // modem control
  input wire logic ring_indicator_in_n_i,
  output logic dtr_n_o,
  output logic rts_n_o,
  output logic loopback_o,
  output logic ring_status_o
);

  // the trigger of 14 must fit in the count
  if (COUNT_W < TRIG_W) begin : g_count_check
    $error("COUNT_W too narrow for the highest trigger level");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic fifo_en;
    logic dma;
    logic [1:0] trig;
    logic rx_rst;
    logic tx_rst;
    logic [7:0] line_format_control;
    logic [7:0] modem_output_control;
    logic rx_trig;
    logic transmit_ready_pin_n_n;
    logic receive_ready_pin_n_n;
    logic [3:0] data_bits;
    logic [2:0] stop_half;
    parity_e parity;
    logic tx_line;
    logic dtr_n;
    logic rts_n;
    logic ring;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [3:0] dec_data_bits;
  logic [2:0] dec_stop_half;
  parity_e dec_parity;
  logic access;
  logic wr_en;
  logic [7:0] wbyte;
  trig_t level;
  logic [COUNT_W-1:0] level_ext;
  logic [7:0] fcr_read;
  logic [7:0] status_read;

  // format decode works on the stored byte so it follows reads back exactly
  line_format_decode u_decode (
    .line_format_control_i(state_reg.line_format_control),
    .data_bits_o(dec_data_bits),
    .stop_half_bits_o(dec_stop_half),
    .parity_mode_o(dec_parity)
  );

  always_comb begin
    state_next = state_reg;
    access = cyc_i && stb_i && !state_reg.ack;
    // only byte lane 0 carries register data
    wr_en = access && we_i && sel_i[0];
    wbyte = dat_i[7:0];

    // bus answer, registered one cycle after the request, dropped after one cycle
    state_next.ack = access;
    state_next.rdata = UNMAPPED_DATA;

    // fifo reset requests are single-cycle pulses
    state_next.rx_rst = 1'b0;
    state_next.tx_rst = 1'b0;

    // fifo_control: write-only, read side shows source status
    if (wr_en && adr_i == FIFO_CTRL_ADDR) begin
      state_next.fifo_en = wbyte[FCR_EN_BIT];
      if (wbyte[FCR_EN_BIT]) begin
        state_next.dma = wbyte[FCR_DMA_BIT];
        state_next.trig = wbyte[FCR_TRIG_LSB +: 2];
        state_next.rx_rst = wbyte[FCR_RXRST_BIT];
        state_next.tx_rst = wbyte[FCR_TXRST_BIT];
      end
    end

    if (wr_en && adr_i == LINE_FMT_ADDR) begin
      state_next.line_format_control = wbyte;
    end

    // unused upper bits are never stored
    if (wr_en && adr_i == MODEM_OUT_ADDR) begin
      state_next.modem_output_control = wbyte & MCR_USED_MASK;
    end

    // read data, zero above the byte
    fcr_read = {{2{state_reg.fifo_en}}, 2'h0, ISR_NONE_PENDING};
    status_read = 8'h00;
    status_read[0] = state_reg.fifo_en;
    status_read[1] = state_reg.rx_trig;
    status_read[2] = state_reg.ring;
    status_read[3] = state_reg.dma;
    status_read[5:4] = state_reg.trig;
    status_read[7:6] = {2{state_reg.fifo_en}};
    if (access && !we_i) begin
      case (adr_i)
        FIFO_CTRL_ADDR: begin
          state_next.rdata = {24'h0, fcr_read};
        end
        LINE_FMT_ADDR: begin
          state_next.rdata = {24'h0, state_reg.line_format_control};
        end
        MODEM_OUT_ADDR: begin
          state_next.rdata = {24'h0, state_reg.modem_output_control};
        end
        CTRL_STATUS_ADDR: begin
          state_next.rdata = {24'h0, status_read};
        end
        default: begin
          state_next.rdata = UNMAPPED_DATA;
        end
      endcase
    end

    // receive threshold
    case (state_reg.trig)
      2'h0: begin
        level = TRIG_LVL_1;
      end
      2'h1: begin
        level = TRIG_LVL_4;
      end
      2'h2: begin
        level = TRIG_LVL_8;
      end
      default: begin
        level = TRIG_LVL_14;
      end
    endcase
    level_ext = COUNT_W'(level);
    // with fifos off there is no threshold to cross
    state_next.rx_trig = state_reg.fifo_en && (rx_fifo_count_i >= level_ext);

    // ready pins; dma mode keeps rx high until the threshold
    if (state_reg.dma && state_reg.fifo_en) begin
      state_next.receive_ready_pin_n_n = !state_next.rx_trig;
      state_next.transmit_ready_pin_n_n = tx_fifo_full_i;
    end else begin
      state_next.receive_ready_pin_n_n = (rx_fifo_count_i == '0);
      state_next.transmit_ready_pin_n_n = !tx_fifo_empty_i;
    end

    // registered format outputs lag the stored byte by one cycle
    state_next.data_bits = dec_data_bits;
    state_next.stop_half = dec_stop_half;
    state_next.parity = dec_parity;

    // break wins over whatever the transmitter sends
    if (state_reg.line_format_control[LCR_BRK_BIT]) begin
      state_next.tx_line = 1'b0;
    end else begin
      state_next.tx_line = tx_serial_i;
    end

    state_next.dtr_n = !state_reg.modem_output_control[MCR_DTR_BIT];
    state_next.rts_n = !state_reg.modem_output_control[MCR_RTS_BIT];

    // output-one has no pin; it only reaches the ring status in loopback
    if (state_reg.modem_output_control[MCR_LOOP_BIT]) begin
      state_next.ring = state_reg.modem_output_control[MCR_OUT1_BIT];
    end else begin
      state_next.ring = !ring_indicator_in_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= UNMAPPED_DATA;
      state_reg.fifo_en <= 1'b0;
      state_reg.dma <= 1'b0;
      state_reg.trig <= TRIG_RESET;
      state_reg.rx_rst <= 1'b0;
      state_reg.tx_rst <= 1'b0;
      state_reg.line_format_control <= LCR_RESET;
      state_reg.modem_output_control <= MCR_RESET;
      state_reg.rx_trig <= 1'b0;
      state_reg.transmit_ready_pin_n_n <= 1'b1;
      state_reg.receive_ready_pin_n_n <= 1'b1;
      state_reg.data_bits <= WLEN_BASE;
      state_reg.stop_half <= STOP_HALF_ONE;
      state_reg.parity <= PAR_NONE;
      state_reg.tx_line <= 1'b1;
      state_reg.dtr_n <= 1'b1;
      state_reg.rts_n <= 1'b1;
      state_reg.ring <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output straight from the state register
  assign ack_o = state_reg.ack;
  assign dat_o = state_reg.rdata;
  assign fifo_enable_o = state_reg.fifo_en;
  assign rx_fifo_reset_o = state_reg.rx_rst;
  assign tx_fifo_reset_o = state_reg.tx_rst;
  assign dma_mode_o = state_reg.dma;
  assign rx_trigger_o = state_reg.rx_trig;
  assign fifo_status_o = {2{state_reg.fifo_en}};
  assign transmit_ready_pin_n_o = state_reg.transmit_ready_pin_n_n;
  assign receive_ready_pin_n_o = state_reg.receive_ready_pin_n_n;
  assign data_bits_o = state_reg.data_bits;
  assign stop_half_bits_o = state_reg.stop_half;
  assign parity_mode_o = state_reg.parity;
  assign divisor_access_o = state_reg.line_format_control[LCR_DLAB_BIT];
  assign tx_line_o = state_reg.tx_line;
  assign dtr_n_o = state_reg.dtr_n;
  assign rts_n_o = state_reg.rts_n;
  assign loopback_o = state_reg.modem_output_control[MCR_LOOP_BIT];
  assign ring_status_o = state_reg.ring;
endmodule
`default_nettype wire

// [bench/ctrl_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module ctrl_sva
  import uart_ctrl_pkg::*;
(
  // bus side
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  // watched outputs and the inputs they follow
  input wire logic fifo_enable_o, rx_fifo_reset_o, tx_fifo_reset_o,
  input wire logic [1:0] fifo_status_o,
  input wire logic tx_serial_i, tx_line_o, dtr_n_o, rts_n_o,
  input wire logic ring_indicator_in_n_i, ring_status_o
);
  logic wr, fcr_wr, fcr_en_wr, brk, line_exp, ring_exp;
  logic [1:0] pins_exp;
  logic [4:0] modem_output_control;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign fcr_wr = wr && adr_i == FIFO_CTRL_ADDR;
  assign fcr_en_wr = fcr_wr && dat_i[0];
  assign line_exp = !brk && tx_serial_i;
  // dtr_n sits above rts_n in the compared pair
  assign pins_exp = {!modem_output_control[0], !modem_output_control[1]};
  assign ring_exp = modem_output_control[4] ? modem_output_control[2] : !ring_indicator_in_n_i;
  // shadow copies rebuilt from bus traffic alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk <= 1'b0;
      modem_output_control <= 5'h00;
    end else begin
      if (wr && adr_i == LINE_FMT_ADDR) brk <= dat_i[6];
      if (wr && adr_i == MODEM_OUT_ADDR) modem_output_control <= dat_i[4:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fifo_enable: assert property (fcr_wr |=> fifo_enable_o == $past(fcr_en_wr))
    else $error("fifo enable differs from write");
  a_reset_gated: assert property (rx_fifo_reset_o || tx_fifo_reset_o |-> $past(fcr_en_wr))
    else $error("fifo reset without enable write");
  a_rx_reset: assert property (fcr_en_wr && dat_i[1] |=> rx_fifo_reset_o ##1 !rx_fifo_reset_o)
    else $error("rx fifo reset pulse wrong");
  a_tx_reset: assert property (fcr_en_wr && dat_i[2] |=> tx_fifo_reset_o ##1 !tx_fifo_reset_o)
    else $error("tx fifo reset pulse wrong");
  a_fifo_status: assert property (fcr_wr |=> fifo_status_o == {2{$past(fcr_en_wr)}})
    else $error("fifo status bits wrong");
  a_break_line: assert property (1'b1 |=> tx_line_o == $past(line_exp))
    else $error("serial output wrong");
  a_modem_pins: assert property (1'b1 |=> {dtr_n_o, rts_n_o} == $past(pins_exp))
    else $error("modem pins wrong");
  a_ring_source: assert property (1'b1 |=> ring_status_o == $past(ring_exp))
    else $error("ring status wrong");
endmodule
bind uart_line_modem_ctrl ctrl_sva i_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
  .adr_i, .sel_i, .dat_i, .fifo_enable_o, .rx_fifo_reset_o, .tx_fifo_reset_o, .fifo_status_o,
  .tx_serial_i, .tx_line_o, .dtr_n_o, .rts_n_o, .ring_indicator_in_n_i, .ring_status_o);
`default_nettype wire

// [bench/modem_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
module modem_far_end (
  input wire logic clk_i,
  input wire logic ring_req_i,
  input wire logic tx_line_i,
  output logic ring_indicator_in_n_o,
  output logic break_seen_o
);
  logic [3:0] low_run = 4'h0;
  initial ring_indicator_in_n_o = 1'b1;
  // ring is active low and only sounds when asked
  always @(posedge clk_i) begin
    ring_indicator_in_n_o <= !ring_req_i;
    if (tx_line_i) low_run <= 4'h0;
    else if (low_run != 4'hf) low_run <= low_run + 4'h1;
  end
  // long space reads as break, short ones as data
  assign break_seen_o = low_run == 4'hf;
endmodule
`default_nettype wire

// [bench/test_uart_line_modem_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module test_uart_line_modem_ctrl;
  import uart_ctrl_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [4:0] rx_fifo_count_i = 5'h00;
  logic tx_fifo_empty_i = 1'b1, tx_fifo_full_i = 1'b0, tx_serial_i = 1'b1, ring_req = 1'b0;
  logic ack_o, fifo_enable_o, rx_fifo_reset_o, tx_fifo_reset_o, dma_mode_o, rx_trigger_o;
  logic transmit_ready_pin_n_o, receive_ready_pin_n_o, divisor_access_o, tx_line_o, break_seen;
  logic ring_indicator_in_n_i, dtr_n_o, rts_n_o, loopback_o, ring_status_o;
  logic [1:0] fifo_status_o;
  logic [3:0] data_bits_o;
  logic [2:0] stop_half_bits_o;
  parity_e parity_mode_o;
  int n_errors = 0, n_tests = 0, cycles = 0, rx_pulses = 0, tx_pulses = 0;
  uart_line_modem_ctrl i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .rx_fifo_count_i, .tx_fifo_empty_i, .tx_fifo_full_i, .fifo_enable_o,
    .rx_fifo_reset_o, .tx_fifo_reset_o, .dma_mode_o, .rx_trigger_o, .fifo_status_o,
    .transmit_ready_pin_n_o, .receive_ready_pin_n_o, .data_bits_o, .stop_half_bits_o,
    .parity_mode_o, .divisor_access_o, .tx_serial_i, .tx_line_o, .ring_indicator_in_n_i,
    .dtr_n_o, .rts_n_o, .loopback_o, .ring_status_o);
  modem_far_end i_far (.clk_i, .ring_req_i(ring_req), .tx_line_i(tx_line_o),
    .ring_indicator_in_n_o(ring_indicator_in_n_i), .break_seen_o(break_seen));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (rx_fifo_reset_o === 1'b1) rx_pulses <= rx_pulses + 1;
    if (tx_fifo_reset_o === 1'b1) tx_pulses <= tx_pulses + 1;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, then one idle cycle so requests never merge
  task automatic bus(input logic wr, input logic [7:0] a, d, output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wb_write(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, q, exp);
  endtask
  task automatic s_reset();
    check("format", {data_bits_o, stop_half_bits_o, parity_mode_o}, 10'h150);
    check("pins", {dtr_n_o, rts_n_o, tx_line_o, fifo_enable_o, divisor_access_o}, 5'h1c);
    rd_check("line", LINE_FMT_ADDR, 32'h0);
    rd_check("modem", MODEM_OUT_ADDR, 32'h0);
    rd_check("fifo", FIFO_CTRL_ADDR, 32'h01);
    rd_check("unmapped", 8'h3c, UNMAPPED_DATA);
  endtask
  task automatic s_fifo();
    logic [4:0] lvl [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    wb_write(FIFO_CTRL_ADDR, 8'hce);
    check("pulses", rx_pulses + tx_pulses, 32'h0);
    check("enable", {fifo_enable_o, dma_mode_o}, 2'h0);
    wb_write(FIFO_CTRL_ADDR, 8'h07);
    check("pulses", rx_pulses * 16 + tx_pulses, 32'h11);
    check("enable", {fifo_enable_o, fifo_status_o, dma_mode_o}, 4'he);
    rd_check("fifo", FIFO_CTRL_ADDR, 32'hc1);
    for (int i = 0; i < 4; i++) begin
      wb_write(FIFO_CTRL_ADDR, {i[1:0], 6'h01});
      rx_fifo_count_i <= lvl[i] - 5'h01;
      repeat (2) @(posedge clk_i);
      check("below", rx_trigger_o, 32'h0);
      rx_fifo_count_i <= lvl[i];
      repeat (2) @(posedge clk_i);
      check("at", rx_trigger_o, 32'h1);
    end
    wb_write(FIFO_CTRL_ADDR, 8'hc9);
    check("ready", {dma_mode_o, receive_ready_pin_n_o, transmit_ready_pin_n_o}, 3'h4);
    rd_check("status", CTRL_STATUS_ADDR, 32'hfb);
    rx_fifo_count_i <= 5'h0d;
    tx_fifo_full_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("ready", {receive_ready_pin_n_o, transmit_ready_pin_n_o}, 2'h3);
    wb_write(FIFO_CTRL_ADDR, 8'h01);
    check("ready", {dma_mode_o, receive_ready_pin_n_o, transmit_ready_pin_n_o}, 3'h0);
    wb_write(FIFO_CTRL_ADDR, 8'h00);
    check("enable", {fifo_enable_o, fifo_status_o}, 3'h0);
  endtask
  task automatic s_format();
    // expected {bits, half stop bits, parity mode} per written byte
    logic [7:0] v [10] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h04, 8'h0b, 8'h1a, 8'h29, 8'h38, 8'h30};
    logic [9:0] e [10] = '{10'h150, 10'h1a0, 10'h1e0, 10'h220, 10'h158, 10'h211, 10'h1d2,
      10'h193, 10'h154, 10'h150};
    for (int i = 0; i < 10; i++) begin
      wb_write(LINE_FMT_ADDR, v[i]);
      check("format", {data_bits_o, stop_half_bits_o, parity_mode_o}, e[i]);
      rd_check("line", LINE_FMT_ADDR, {24'h0, v[i]});
    end
    wb_write(LINE_FMT_ADDR, 8'hc0);
    repeat (16) @(posedge clk_i);
    check("break", {tx_line_o, divisor_access_o, break_seen}, 3'h3);
    wb_write(LINE_FMT_ADDR, 8'h00);
    tx_serial_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("follow", {tx_line_o, divisor_access_o, break_seen}, 3'h0);
    tx_serial_i <= 1'b1;
  endtask
  task automatic s_modem();
    ring_req <= 1'b1;
    wb_write(MODEM_OUT_ADDR, 8'hff);
    rd_check("modem", MODEM_OUT_ADDR, 32'h1f);
    check("pins", {dtr_n_o, rts_n_o, loopback_o, ring_status_o}, 4'h3);
    wb_write(MODEM_OUT_ADDR, 8'h10);
    check("ring", ring_status_o, 32'h0);
    wb_write(MODEM_OUT_ADDR, 8'h02);
    check("pins", {dtr_n_o, rts_n_o, loopback_o, ring_status_o}, 4'h9);
    wb_write(8'h3c, 8'hff);
    rd_check("modem", MODEM_OUT_ADDR, 32'h02);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_fifo();
    s_format();
    s_modem();
    wrap_up();
  end
endmodule
`default_nettype wire
